// *** bench/altimeter_i2c_command_slave_bench.sv ***
// Self-checking bench joining controller and sensor ends over the link
`timescale 1ns/1ps
`include "altimeter_params.svh"
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; $display("wrong value at %0t: %h expected %h", $time, got, exp); end end

module altimeter_i2c_command_slave_bench;
  localparam logic [6:0][15:0] CAL = {16'h7A5C, 16'h6B4D, 16'h5C3E, 16'h4D2F, 16'h3E10, 16'h2F01, 16'h1F23};
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, busy, valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] raw_p, raw_t;
  int n_mismatch, checks_done;

  altimeter_link_if link_bus ();
  altimeter_host_end #(.SCL_QTR(8)) u_altimeter_host_end (.i_clock(clock), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .link(link_bus));
  altimeter_sensor_end #(.CAL_INIT(CAL), .CONVERT_FLAG_BIT_CYC('{200, 300, 400, 500, 600, 3000})) u_altimeter_sensor_end (
    .i_clock(clock), .i_rst_n(rst_n), .link(link_bus), .i_raw_pressure_value(raw_p),
    .i_raw_temperature_value(raw_t), .o_busy(busy), .o_result_valid(valid));
  altimeter_link_props u_altimeter_link_props (.i_clock(clock), .i_rst_n(rst_n), .scl(link_bus.scl),
    .host_sda_oe(link_bus.host_sda_oe), .sensor_sda_oe(link_bus.sensor_sda_oe), .o_busy(busy),
    .o_result_valid(valid));

  always #2.5 clock = ~clock;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic give_up(input logic hit);
    if (hit)
    begin
      n_mismatch++;
      $display("wrong value at %0t: wait ran out", $time);
      end_sim;
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    give_up(n >= 50);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic link(input logic [1:0] op, input logic [7:0] cmd);
    int n;
    pwdata <= {22'h0, op, cmd};
    apb(1'b1, `CTRL_OFS);
    n = 0;
    do
    begin
      apb(1'b0, `STAT_OFS);
      n++;
    end
    while (rd[`STAT_BUSY_BIT] !== 1'b0 && n < 1000);
    give_up(n >= 1000);
    `CHECK(rd[`STAT_NACK_BIT], 1'b0)
    apb(1'b0, `DATA_OFS);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 4000)
    begin
      @(posedge clock);
      n++;
    end
    give_up(n >= 4000);
  endtask

  function automatic logic [3:0] crc4(input logic [6:0][15:0] w);
    logic [15:0] rem;
    logic [15:0] word;
    rem = 16'h0;
    for (int c = 0; c < 16; c++)
    begin
      word = (c > 13) ? 16'h0 : (c < 2) ? (w[0] & 16'h0FFF) : w[c >> 1];
      rem = rem ^ ((c % 2) ? {8'h0, word[7:0]} : {8'h0, word[15:8]});
      for (int b = 0; b < 8; b++)
        rem = rem[15] ? ((rem << 1) ^ 16'h3000) : (rem << 1);
    end
    return rem[15:12];
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    raw_p = 24'hA1_B2C3;
    raw_t = 24'h3C_5D7E;
    n_mismatch = 0;
    checks_done = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, 8'h0C);
    `CHECK(pslverr, 1'b1)
    `CHECK(rd, 32'h0)
    link(2'd0, 8'hA2);
    link(2'd1, 8'h00);
    `CHECK(rd[15:0], 16'h0)
    link(2'd0, `CMD_RESET);
    for (int i = 0; i < 8; i++)
    begin
      link(2'd0, 8'(`CMD_PROM + i * 2));
      link(2'd1, 8'h00);
      `CHECK(rd[15:0], i == 7 ? 16'h0 : i == 0 ? {crc4(CAL), CAL[0][11:0]} : CAL[i])
    end
    for (int k = 0; k < 12; k++)
    begin
      link(2'd0, 8'(`CMD_CONVERT_FLAG_BIT + (k / 6) * 16 + (k % 6) * 2));
      `CHECK(busy, 1'b1)
      wait_idle;
      `CHECK(valid, 1'b1)
      link(2'd0, `CMD_ADC_READ);
      link(2'd2, 8'h00);
      `CHECK(rd[23:0], k < 6 ? raw_p : raw_t)
    end
    link(2'd0, `CMD_ADC_READ);
    link(2'd2, 8'h00);
    `CHECK(rd[23:0], 24'h0)
    link(2'd0, 8'h4A);
    link(2'd0, `CMD_ADC_READ);
    link(2'd2, 8'h00);
    `CHECK(rd[23:0], 24'h0)
    wait_idle;
    link(2'd0, 8'h33);
    `CHECK(valid, 1'b1)
    link(2'd0, `CMD_ADC_READ);
    link(2'd2, 8'h00);
    `CHECK(rd[23:0], ~raw_p)
    link(2'd0, 8'h50);
    wait_idle;
    link(2'd3, 8'h00);
    link(2'd0, `CMD_RESET);
    `CHECK(valid, 1'b0)
    link(2'd0, 8'hA2);
    link(2'd1, 8'h00);
    `CHECK(rd[15:0], CAL[1])
    end_sim;
  end
endmodule

// *** bench/altimeter_link_props.sv ***
// Concurrent checks on the two-wire link and the sensor status
`timescale 1ns/1ps
module altimeter_link_props (
  // Clock, reset and link
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic sensor_sda_oe,
  // Sensor status
  input wire logic o_busy,
  input wire logic o_result_valid
);
  logic [11:0] busy_len_reg;
  logic [11:0] busy_len_next;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  // Length of the current conversion
  always_comb
  begin
    busy_len_next = o_busy ? busy_len_reg + 12'h001 : 12'h000;
  end

  always_ff @(posedge i_clock)
  begin
    busy_len_reg <= busy_len_next;
  end

  AST_IDLE_AFTER_RESET: assert property (disable iff (1'b0) !i_rst_n |=> scl && !host_sda_oe && !sensor_sda_oe)
    else $error("link not idle after reset");
  AST_SENSOR_OE_SCL_LOW: assert property ($changed(sensor_sda_oe) |-> !scl)
    else $error("sensor moved data while clock high");
  AST_SENSOR_OE_LAG: assert property ($fell(scl) |-> ##1 $stable(sensor_sda_oe) [*2])
    else $error("sensor moved data too soon after clock fall");
  AST_SENSOR_OE_BOUND: assert property ($rose(sensor_sda_oe) |-> ##[1:400] !sensor_sda_oe)
    else $error("sensor held data low too long");
  AST_VALID_NOT_BUSY: assert property (o_busy |-> !o_result_valid)
    else $error("result valid during conversion");
  AST_VALID_AFTER_BUSY: assert property ($fell(o_busy) |-> ##[0:1] o_result_valid)
    else $error("no result after conversion");
  AST_VALID_FROM_BUSY: assert property ($rose(o_result_valid) |-> $past(o_busy) || $past(o_busy, 2))
    else $error("result without conversion");
  AST_BUSY_MIN: assert property ($fell(o_busy) |-> busy_len_reg >= 12'h0BE)
    else $error("conversion too short");
  AST_BUSY_MAX: assert property (busy_len_reg <= 12'hC1C)
    else $error("conversion too long");
endmodule

// *** core/altimeter_host_end.sv ***
// Controller end: APB-programmed two-wire master for the altimeter sensor
`timescale 1ns/1ps
`include "altimeter_params.svh"

module altimeter_host_end #(
  parameter int unsigned SCL_QTR = `SCL_QTR_CYC
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Link pins
  altimeter_link_if.host_end link
);

  altimeter_pkg::host_state_type state_reg, state_next;
  altimeter_pkg::host_op_type op_reg, op_next;
  logic [1:0] phase_reg, phase_next, byte_reg, byte_next, last_reg, last_next;
  logic [15:0] tick_reg, tick_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] cmd_reg, cmd_next, shift_reg, shift_next;
  logic [23:0] rx_reg, rx_next;
  logic nack_reg, nack_next, scl_reg, scl_next, oe_reg, oe_next;
  logic [2:0] sync_reg, sync_next;
  logic sda_reg, sda_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic tick, tx_byte, wr_ctrl;

  always_comb
  begin
    sync_next = {sync_reg[1:0], link.sda};
    sda_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : sda_reg;
    tick = (tick_reg == 16'(SCL_QTR - 1));
    tick_next = tick ? 16'h0000 : tick_reg + 16'h0001;
    tx_byte = (op_reg == altimeter_pkg::OP_WRITE) || (byte_reg == 2'h0);
    wr_ctrl = i_psel & i_penable & i_pwrite & (i_paddr == `CTRL_OFS);
    state_next = state_reg;
    op_next = op_reg;
    phase_next = phase_reg;
    byte_next = byte_reg;
    last_next = last_reg;
    bit_next = bit_reg;
    cmd_next = cmd_reg;
    shift_next = shift_reg;
    rx_next = rx_reg;
    nack_next = nack_reg;
    scl_next = scl_reg;
    oe_next = oe_reg;

    // ****************************************
    // Register access
    // ****************************************
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (i_psel && !i_penable)
    begin
      pslverr_next = 1'b0;
      prdata_next = 32'h0000_0000;
      case (i_paddr)
        `CTRL_OFS: prdata_next = {22'h00_0000, op_reg, cmd_reg};
        `STAT_OFS: prdata_next = {30'h0000_0000, nack_reg, state_reg != altimeter_pkg::H_IDLE};
        `DATA_OFS: prdata_next = {8'h00, rx_reg};
        default: pslverr_next = 1'b1;
      endcase
    end
    if (wr_ctrl && state_reg == altimeter_pkg::H_IDLE)
    begin
      cmd_next = i_pwdata[7:0];
      op_next = altimeter_pkg::host_op_type'(i_pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB]);
      last_next = i_pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB] == 2'h3 ? 2'h0 : i_pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB] + 2'h1;
      nack_next = 1'b0;
      rx_next = 24'h00_0000;
      phase_next = 2'h0;
      byte_next = 2'h0;
      bit_next = 4'h0;
      shift_next = 8'hFF;
      state_next = (i_pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB] == 2'h3) ? altimeter_pkg::H_BIT : altimeter_pkg::H_START;
    end

    // ****************************************
    // Bit engine, four ticks per bit
    // ****************************************
    else if (tick)
    begin
      phase_next = phase_reg + 2'h1;
      case (state_reg)
        altimeter_pkg::H_START:
        begin
          case (phase_reg)
            2'h0:
            begin
              scl_next = 1'b1;
              oe_next = 1'b0;
            end
            2'h1: oe_next = 1'b1;
            2'h2: scl_next = 1'b0;
            default:
            begin
              state_next = altimeter_pkg::H_BIT;
              shift_next = {`SENSOR_ADDR, op_reg != altimeter_pkg::OP_WRITE};
            end
          endcase
        end
        altimeter_pkg::H_BIT:
        begin
          case (phase_reg)
            2'h0: scl_next = 1'b0;
            2'h1:
            begin
              if (bit_reg != `BYTE_BITS)
              begin
                oe_next = tx_byte & ~shift_reg[7];
              end
              else
              begin
                oe_next = ~tx_byte & (byte_reg != last_reg);
              end
            end
            2'h2: scl_next = 1'b1;
            default:
            begin
              if (bit_reg != `BYTE_BITS)
              begin
                shift_next = {shift_reg[6:0], sda_reg};
                bit_next = bit_reg + 4'h1;
              end
              else
              begin
                bit_next = 4'h0;
                if (!tx_byte)
                begin
                  rx_next = {rx_reg[15:0], shift_reg};
                end
                if (tx_byte && sda_reg && op_reg != altimeter_pkg::OP_RECOVER)
                begin
                  nack_next = 1'b1;
                  state_next = altimeter_pkg::H_STOP;
                end
                else if (byte_reg == last_reg)
                begin
                  state_next = altimeter_pkg::H_STOP;
                end
                else
                begin
                  byte_next = byte_reg + 2'h1;
                  shift_next = cmd_reg;
                end
              end
            end
          endcase
        end
        altimeter_pkg::H_STOP:
        begin
          case (phase_reg)
            2'h0:
            begin
              scl_next = 1'b0;
              oe_next = 1'b1;
            end
            2'h1: scl_next = 1'b1;
            2'h2: oe_next = 1'b0;
            default: state_next = altimeter_pkg::H_IDLE;
          endcase
        end
        default: phase_next = 2'h0;
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      state_reg <= altimeter_pkg::H_IDLE;
      op_reg <= altimeter_pkg::OP_WRITE;
      phase_reg <= 2'h0;
      byte_reg <= 2'h0;
      last_reg <= 2'h0;
      tick_reg <= 16'h0000;
      bit_reg <= 4'h0;
      cmd_reg <= 8'h00;
      shift_reg <= 8'h00;
      rx_reg <= 24'h00_0000;
      nack_reg <= 1'b0;
      scl_reg <= 1'b1;
      oe_reg <= 1'b0;
      sync_reg <= 3'h7;
      sda_reg <= 1'b1;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      op_reg <= op_next;
      phase_reg <= phase_next;
      byte_reg <= byte_next;
      last_reg <= last_next;
      tick_reg <= tick_next;
      bit_reg <= bit_next;
      cmd_reg <= cmd_next;
      shift_reg <= shift_next;
      rx_reg <= rx_next;
      nack_reg <= nack_next;
      scl_reg <= scl_next;
      oe_reg <= oe_next;
      sync_reg <= sync_next;
      sda_reg <= sda_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = 1'b1;
  assign o_pslverr = pslverr_reg;
  assign link.scl = scl_reg;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = oe_reg;

endmodule

// *** core/altimeter_link_if.sv ***
// Two-wire link between controller and sensor, with open-drain data resolution
`timescale 1ns/1ps
interface altimeter_link_if;
  logic scl;
  logic sda;
  logic host_sda_o;
  logic host_sda_oe;
  logic sensor_sda_o;
  logic sensor_sda_oe;

  // Wired-AND data line with pull-up
  assign sda = ~((host_sda_oe & ~host_sda_o) | (sensor_sda_oe & ~sensor_sda_o));

  modport host_end (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport sensor_end (input scl, input sda, output sensor_sda_o, output sensor_sda_oe);
endinterface

// *** core/altimeter_params.svh ***
// Offsets, field positions, command codes and timing counts of the altimeter link
`ifndef ALTIMETER_PARAMS_SVH
`define ALTIMETER_PARAMS_SVH

// Bus address and command codes
`define SENSOR_ADDR 7'h76
`define CMD_RESET 8'h1E
`define CMD_ADC_READ 8'h00
`define CMD_CONVERT_FLAG_BIT 8'h40
`define CMD_CONVERT_FLAG_BIT_MASK 8'hE1
`define CMD_PROM 8'hA0
`define CMD_PROM_MASK 8'hF1
`define CONVERT_FLAG_BIT_TEMP_BIT 4
`define SEL_MSB 3
`define SEL_LSB 1
`define RATIO_MAX 3'h5
`define BYTE_BITS 4'h8
`define CRC_MSB 15
`define CRC_LSB 12

// Timing
`define CLK_KHZ 200000
`define CLK_PERIOD_NS 5
`define CONVERT_FLAG_BIT_MS_256 0.54
`define CONVERT_FLAG_BIT_MS_512 1.06
`define CONVERT_FLAG_BIT_MS_1024 2.08
`define CONVERT_FLAG_BIT_MS_2048 4.13
`define CONVERT_FLAG_BIT_MS_4096 8.22
`define CONVERT_FLAG_BIT_MS_8192 16.44
`define SCL_PERIOD_NS 2500
`define SCL_QTR_CYC ((`SCL_PERIOD_NS / 4 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Controller register map
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
`define DATA_OFS 8'h08
`define CTRL_OP_MSB 9
`define CTRL_OP_LSB 8
`define STAT_BUSY_BIT 0
`define STAT_NACK_BIT 1

`endif

// *** core/altimeter_pkg.sv ***
// Shared state, mode and operation types of the altimeter link
package altimeter_pkg;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ADDR_ACK, S_WRITE, S_WRITE_ACK, S_READ, S_READ_ACK} sensor_state_type;
  typedef enum logic [1:0] {M_NONE, M_ADC, M_PROM} sensor_mode_type;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_type;
  typedef enum logic [1:0] {OP_WRITE, OP_READ2, OP_READ3, OP_RECOVER} host_op_type;
endpackage

// *** core/altimeter_sensor_end.sv ***
// Sensor end: two-wire command slave with conversion timing and calibration memory
//
`timescale 1ns/1ps
`include "altimeter_params.svh"

module altimeter_sensor_end #(
  parameter logic [6:0][15:0] CAL_INIT = {16'h0007, 16'h0006, 16'h0005, 16'h0004, 16'h0003, 16'h0002, 16'h0001},
  parameter int unsigned CONVERT_FLAG_BIT_CYC [0:5] = '{int'(`CONVERT_FLAG_BIT_MS_256 * `CLK_KHZ), int'(`CONVERT_FLAG_BIT_MS_512 * `CLK_KHZ),
    int'(`CONVERT_FLAG_BIT_MS_1024 * `CLK_KHZ), int'(`CONVERT_FLAG_BIT_MS_2048 * `CLK_KHZ), int'(`CONVERT_FLAG_BIT_MS_4096 * `CLK_KHZ),
    int'(`CONVERT_FLAG_BIT_MS_8192 * `CLK_KHZ)}
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Link pins
  altimeter_link_if.sensor_end link,
  // Sensing front end
  input wire logic [23:0] i_raw_pressure_value,
  input wire logic [23:0] i_raw_temperature_value,
  // Status
  output logic o_busy,
  output logic o_result_valid
);

  // ****************************************
  // Checksum over the calibration image
  // ****************************************
  function automatic logic [3:0] crc4(input logic [6:0][15:0] words);
    logic [7:0][15:0] w;
    logic [15:0] rem;
    logic [7:0] data;
    w = {16'h0000, words};
    w[0][15:12] = 4'h0;
    rem = 16'h0000;
    for (int b = 0; b < 16; b++)
    begin
      data = b[0] ? w[b >> 1][7:0] : w[b >> 1][15:8];
      rem = rem ^ {8'h00, data};
      for (int k = 0; k < 8; k++)
      begin
        rem = rem[15] ? ((rem << 1) ^ 16'h3000) : (rem << 1);
      end
    end
    return rem[15:12];
  endfunction

  // ****************************************
  // State
  // ****************************************
  altimeter_pkg::sensor_state_type state_reg, state_next;
  altimeter_pkg::sensor_mode_type mode_reg, mode_next;
  logic [2:0] scl_sync_reg, scl_sync_next, sda_sync_reg, sda_sync_next;
  logic scl_reg, scl_next, sda_reg, sda_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [23:0] tx_reg, tx_next;
  logic read_reg, read_next, ack_reg, ack_next, oe_reg, oe_next;
  logic [2:0] word_reg, word_next;
  logic [15:0] cal_reg [0:6];
  logic [15:0] cal_next [0:6];
  logic [23:0] result_reg, result_next;
  logic valid_reg, valid_next, busy_reg, busy_next;
  logic corrupt_reg, corrupt_next, temp_reg, temp_next;
  logic [31:0] timer_reg, timer_next;
  logic scl_rise, scl_fall, start_seen, stop_seen;

  always_comb
  begin
    scl_sync_next = {scl_sync_reg[1:0], link.scl};
    sda_sync_next = {sda_sync_reg[1:0], link.sda};
    scl_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_reg;
    sda_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_reg;
    scl_rise = scl_next & ~scl_reg;
    scl_fall = ~scl_next & scl_reg;
    start_seen = scl_reg & scl_next & sda_reg & ~sda_next;
    stop_seen = scl_reg & scl_next & ~sda_reg & sda_next;
    state_next = state_reg;
    mode_next = mode_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    read_next = read_reg;
    ack_next = ack_reg;
    oe_next = oe_reg;
    word_next = word_reg;
    cal_next = cal_reg;
    result_next = result_reg;
    valid_next = valid_reg;
    busy_next = busy_reg;
    corrupt_next = corrupt_reg;
    temp_next = temp_reg;
    timer_next = timer_reg;

    // Conversion timer
    if (busy_reg)
    begin
      if (timer_reg == 32'h0000_0000)
      begin
        busy_next = 1'b0;
        valid_next = 1'b1;
        result_next = temp_reg ? i_raw_temperature_value : i_raw_pressure_value;
        if (corrupt_reg)
        begin
          result_next = ~result_next;
        end
      end
      else
      begin
        timer_next = timer_reg - 32'h0000_0001;
      end
    end

    // Bus engine
    if (start_seen)
    begin
      state_next = altimeter_pkg::S_ADDR;
      bit_cnt_next = 4'h0;
      oe_next = 1'b0;
    end
    else if (stop_seen)
    begin
      state_next = altimeter_pkg::S_IDLE;
      oe_next = 1'b0;
    end
    else if (scl_rise)
    begin
      case (state_reg)
        altimeter_pkg::S_ADDR, altimeter_pkg::S_WRITE:
        begin
          shift_next = {shift_reg[6:0], sda_reg};
          bit_cnt_next = bit_cnt_reg + 4'h1;
        end
        altimeter_pkg::S_READ: bit_cnt_next = bit_cnt_reg + 4'h1;
        altimeter_pkg::S_READ_ACK: ack_next = ~sda_reg;
        default: ;
      endcase
    end
    else if (scl_fall)
    begin
      case (state_reg)
        altimeter_pkg::S_ADDR:
        begin
          if (bit_cnt_reg == `BYTE_BITS)
          begin
            if (shift_reg[7:1] == `SENSOR_ADDR)
            begin
              state_next = altimeter_pkg::S_ADDR_ACK;
              oe_next = 1'b1;
              read_next = shift_reg[0];
              tx_next = 24'h00_0000;
              if (shift_reg[0] && mode_reg == altimeter_pkg::M_ADC)
              begin
                if (busy_reg)
                begin
                  corrupt_next = 1'b1;
                end
                else
                begin
                  tx_next = valid_reg ? result_reg : 24'h00_0000;
                  valid_next = 1'b0;
                end
              end
              else if (shift_reg[0] && mode_reg == altimeter_pkg::M_PROM && word_reg < 3'h7)
              begin
                tx_next = {cal_reg[word_reg], 8'h00};
              end
            end
            else
            begin
              state_next = altimeter_pkg::S_IDLE;
            end
          end
        end
        altimeter_pkg::S_ADDR_ACK:
        begin
          bit_cnt_next = 4'h0;
          state_next = read_reg ? altimeter_pkg::S_READ : altimeter_pkg::S_WRITE;
          oe_next = read_reg & ~tx_reg[23];
        end
        altimeter_pkg::S_WRITE:
        begin
          if (bit_cnt_reg == `BYTE_BITS)
          begin
            oe_next = 1'b1;
            state_next = altimeter_pkg::S_WRITE_ACK;
            if (shift_reg == `CMD_RESET)
            begin
              for (int i = 0; i < 7; i++)
              begin
                cal_next[i] = CAL_INIT[i];
              end
              cal_next[0][`CRC_MSB:`CRC_LSB] = crc4(CAL_INIT);
              mode_next = altimeter_pkg::M_NONE;
              busy_next = 1'b0;
              valid_next = 1'b0;
              corrupt_next = 1'b0;
            end
            else if ((shift_reg & `CMD_CONVERT_FLAG_BIT_MASK) == `CMD_CONVERT_FLAG_BIT && shift_reg[`SEL_MSB:`SEL_LSB] <= `RATIO_MAX)
            begin
              mode_next = altimeter_pkg::M_NONE;
              if (busy_reg)
              begin
                corrupt_next = 1'b1;
              end
              else
              begin
                busy_next = 1'b1;
                valid_next = 1'b0;
                corrupt_next = 1'b0;
                temp_next = shift_reg[`CONVERT_FLAG_BIT_TEMP_BIT];
                timer_next = CONVERT_FLAG_BIT_CYC[shift_reg[`SEL_MSB:`SEL_LSB]] - 32'h0000_0001;
              end
            end
            else if (shift_reg == `CMD_ADC_READ)
            begin
              mode_next = altimeter_pkg::M_ADC;
            end
            else if ((shift_reg & `CMD_PROM_MASK) == `CMD_PROM)
            begin
              mode_next = altimeter_pkg::M_PROM;
              word_next = shift_reg[`SEL_MSB:`SEL_LSB];
            end
            // Any other byte is acknowledged and dropped
          end
        end
        altimeter_pkg::S_WRITE_ACK:
        begin
          oe_next = 1'b0;
          bit_cnt_next = 4'h0;
          state_next = altimeter_pkg::S_WRITE;
        end
        altimeter_pkg::S_READ:
        begin
          tx_next = {tx_reg[22:0], 1'b0};
          if (bit_cnt_reg == `BYTE_BITS)
          begin
            oe_next = 1'b0;
            state_next = altimeter_pkg::S_READ_ACK;
          end
          else
          begin
            oe_next = ~tx_reg[22];
          end
        end
        altimeter_pkg::S_READ_ACK:
        begin
          bit_cnt_next = 4'h0;
          state_next = ack_reg ? altimeter_pkg::S_READ : altimeter_pkg::S_IDLE;
          oe_next = ack_reg & ~tx_reg[23];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      state_reg <= altimeter_pkg::S_IDLE;
      mode_reg <= altimeter_pkg::M_NONE;
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 24'h00_0000;
      read_reg <= 1'b0;
      ack_reg <= 1'b0;
      oe_reg <= 1'b0;
      word_reg <= 3'h0;
      for (int i = 0; i < 7; i++)
      begin
        cal_reg[i] <= 16'h0000;
      end
      result_reg <= 24'h00_0000;
      valid_reg <= 1'b0;
      busy_reg <= 1'b0;
      corrupt_reg <= 1'b0;
      temp_reg <= 1'b0;
      timer_reg <= 32'h0000_0000;
    end
    else
    begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      scl_sync_reg <= scl_sync_next;
      sda_sync_reg <= sda_sync_next;
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      read_reg <= read_next;
      ack_reg <= ack_next;
      oe_reg <= oe_next;
      word_reg <= word_next;
      cal_reg <= cal_next;
      result_reg <= result_next;
      valid_reg <= valid_next;
      busy_reg <= busy_next;
      corrupt_reg <= corrupt_next;
      temp_reg <= temp_next;
      timer_reg <= timer_next;
    end
  end

  assign link.sensor_sda_o = 1'b0;
  assign link.sensor_sda_oe = oe_reg;
  assign o_busy = busy_reg;
  assign o_result_valid = valid_reg;

endmodule
